// ---- hdl/slave_cmd.sv ----
// serial slave command handler for read, single write and diagnosis echo
`timescale 1ns/10ps
module slave_cmd
    import slave_cmd_pkg::*;
#(
    parameter int ADDR_W = 13
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // configuration
    input  wire logic [7:0]          own_addr,
    // received bytes, framed by the uart layer
    input  wire logic                rx_valid,
    input  wire logic [7:0]          rx_data,
    input  wire logic                rx_frame_end,
    // transmitted bytes
    output logic                     tx_valid,
    output logic [7:0]               tx_data,
    input  wire logic                tx_ready,
    output logic                     tx_frame_end,
    // register space access
    output logic                     reg_rd,
    output logic                     reg_wr,
    output logic [ADDR_W-1:0]        reg_addr,
    output logic [15:0]              reg_wdata,
    input  wire logic [15:0]         reg_rdata
);
    import slave_cmd_pkg::*;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    slave_state_e      state_q, state_d;
    logic [7:0]        qbuf_q [QUERY_LEN], qbuf_d [QUERY_LEN];
    logic [7:0]        tbuf_q [QUERY_LEN], tbuf_d [QUERY_LEN];
    logic [3:0]        cnt_q, cnt_d;
    logic [3:0]        len_q, len_d;
    logic [15:0]       crc_q, crc_d;
    logic [15:0]       addr_q, addr_d;
    logic [15:0]       left_q, left_d;
    logic              lo_q, lo_d;
    logic [7:0]        lo_byte_q, lo_byte_d;
    logic              rd_phase_q, rd_phase_d;
    logic              ovf_q, ovf_d;
    logic [7:0]        tx_q, tx_d;
    logic              txv_q, txv_d;
    logic              end_q, end_d;
    logic              wr_q, wr_d;
    logic              rd_q, rd_d;
    logic [15:0]       wdat_q, wdat_d;

    wire logic [7:0]  q_fc    = qbuf_q[1];
    wire logic [15:0] q_w1    = {qbuf_q[2], qbuf_q[3]};
    wire logic [15:0] q_w2    = {qbuf_q[4], qbuf_q[5]};
    wire logic [15:0] q_crc   = {qbuf_q[7], qbuf_q[6]};
    wire logic [16:0] rd_end  = {1'b0, q_w1} + {1'b0, q_w2};

    always_comb begin
        state_d    = state_q;
        qbuf_d     = qbuf_q;
        tbuf_d     = tbuf_q;
        cnt_d      = cnt_q;
        len_d      = len_q;
        crc_d      = crc_q;
        addr_d     = addr_q;
        left_d     = left_q;
        lo_d       = lo_q;
        lo_byte_d  = lo_byte_q;
        rd_phase_d = rd_phase_q;
        ovf_d      = ovf_q;
        tx_d       = tx_q;
        txv_d      = 1'b0;
        end_d      = 1'b0;
        wr_d       = 1'b0;
        rd_d       = 1'b0;
        wdat_d     = wdat_q;
        unique case (state_q)
            ST_RX: begin
                if (rx_valid) begin
                    if (cnt_q < QUERY_LEN) begin
                        qbuf_d[cnt_q[2:0]] = rx_data;
                        if (cnt_q < QUERY_LEN - 4'h2) begin
                            crc_d = crc_byte(crc_q, rx_data);
                        end
                        cnt_d = cnt_q + 4'h1;
                    end else begin
                        ovf_d = 1'b1;
                    end
                end
                if (rx_frame_end) begin
                    cnt_d = '0;
                    crc_d = CRC_INIT;
                    ovf_d = 1'b0;
                    // complete eight-byte query, good check, our or broadcast address
                    if (!ovf_q && cnt_q == QUERY_LEN && crc_q == q_crc
                        && (qbuf_q[0] == own_addr || qbuf_q[0] == BCAST_ADDR)) begin
                        state_d = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                tbuf_d     = qbuf_q;
                len_d      = QUERY_LEN - 4'h2;
                rd_phase_d = 1'b0;
                cnt_d      = '0;
                crc_d      = CRC_INIT;
                if (q_fc == FC_READ) begin
                    if (q_w2 == 16'h0000 || q_w2 > MAX_REGS) begin
                        tbuf_d[1] = q_fc + FC_EXC_FLAG;
                        tbuf_d[2] = EXC_DATA;
                        len_d     = EXC_LEN;
                    end else if (rd_end > {1'b0, REG_LIMIT}) begin
                        tbuf_d[1] = q_fc + FC_EXC_FLAG;
                        tbuf_d[2] = EXC_ADDR;
                        len_d     = EXC_LEN;
                    end else begin
                        tbuf_d[2]  = {q_w2[6:0], 1'b0};
                        len_d      = READ_HDR_LEN;
                        rd_phase_d = 1'b1;
                        addr_d     = q_w1;
                        left_d     = q_w2;
                        lo_d       = 1'b0;
                    end
                end else if (q_fc == FC_WRITE) begin
                    if (q_w1 >= REG_LIMIT) begin
                        tbuf_d[1] = q_fc + FC_EXC_FLAG;
                        tbuf_d[2] = EXC_ADDR;
                        len_d     = EXC_LEN;
                    end else begin
                        wr_d   = 1'b1;
                        addr_d = q_w1;
                        wdat_d = q_w2;
                    end
                end else if (q_fc == FC_DIAG && q_w1 == DIAG_SUB_ECHO) begin
                    len_d = QUERY_LEN - 4'h2;
                end else begin
                    tbuf_d[1] = q_fc + FC_EXC_FLAG;
                    tbuf_d[2] = EXC_FUNC;
                    len_d     = EXC_LEN;
                end
                // broadcast: act but stay silent
                state_d = (qbuf_q[0] == BCAST_ADDR) ? ST_RX : ST_TX;
            end
            ST_TX: begin
                if (!txv_q || tx_ready) begin
                    if (cnt_q < len_q) begin
                        tx_d  = tbuf_q[cnt_q[2:0]];
                        txv_d = 1'b1;
                        crc_d = crc_byte(crc_q, tbuf_q[cnt_q[2:0]]);
                        cnt_d = cnt_q + 4'h1;
                    end else if (rd_phase_q && left_q != 16'h0000) begin
                        if (lo_q) begin
                            tx_d   = lo_byte_q;
                            txv_d  = 1'b1;
                            crc_d  = crc_byte(crc_q, lo_byte_q);
                            lo_d   = 1'b0;
                            left_d = left_q - 16'h0001;
                            addr_d = addr_q + 16'h0001;
                        end else begin
                            rd_d    = 1'b1;
                            state_d = ST_FETCH;
                        end
                    end else begin
                        state_d = ST_CRC_LO;
                    end
                end else begin
                    txv_d = 1'b1;
                end
            end
            ST_FETCH: begin
                // one-cycle register space latency; word held whole so halves match
                tx_d      = reg_rdata[15:8];
                lo_byte_d = reg_rdata[7:0];
                txv_d     = 1'b1;
                crc_d     = crc_byte(crc_q, reg_rdata[15:8]);
                lo_d      = 1'b1;
                state_d   = ST_TX;
            end
            ST_CRC_LO: begin
                // entered only after the last data byte left, so nothing is pending here
                tx_d    = crc_q[7:0];
                txv_d   = 1'b1;
                state_d = ST_CRC_HI;
            end
            ST_CRC_HI: begin
                txv_d = 1'b1;
                if (tx_ready) begin
                    tx_d    = crc_q[15:8];
                    end_d   = 1'b1;
                    cnt_d   = '0;
                    crc_d   = CRC_INIT;
                    state_d = ST_RX;
                end
            end
        endcase
        if (state_q == ST_CRC_HI && tx_ready) begin
            txv_d = 1'b1;
        end
        if (state_q == ST_RX && txv_q && !tx_ready) begin
            txv_d = 1'b1;
            end_d = end_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ST_RX;
            qbuf_q     <= '{default: 8'h00};
            tbuf_q     <= '{default: 8'h00};
            cnt_q      <= '0;
            len_q      <= '0;
            crc_q      <= CRC_INIT;
            addr_q     <= '0;
            left_q     <= '0;
            lo_q       <= 1'b0;
            lo_byte_q  <= '0;
            rd_phase_q <= 1'b0;
            ovf_q      <= 1'b0;
            tx_q       <= '0;
            txv_q      <= 1'b0;
            end_q      <= 1'b0;
            wr_q       <= 1'b0;
            rd_q       <= 1'b0;
            wdat_q     <= '0;
        end else begin
            state_q    <= state_d;
            qbuf_q     <= qbuf_d;
            tbuf_q     <= tbuf_d;
            cnt_q      <= cnt_d;
            len_q      <= len_d;
            crc_q      <= crc_d;
            addr_q     <= addr_d;
            left_q     <= left_d;
            lo_q       <= lo_d;
            lo_byte_q  <= lo_byte_d;
            rd_phase_q <= rd_phase_d;
            ovf_q      <= ovf_d;
            tx_q       <= tx_d;
            txv_q      <= txv_d;
            end_q      <= end_d;
            wr_q       <= wr_d;
            rd_q       <= rd_d;
            wdat_q     <= wdat_d;
        end
    end

    assign tx_valid     = txv_q;
    assign tx_data      = tx_q;
    assign tx_frame_end = end_q;
    assign reg_rd       = rd_q;
    assign reg_wr       = wr_q;
    assign reg_addr     = addr_q[ADDR_W-1:0];
    assign reg_wdata    = wdat_q;
endmodule

// ---- hdl/slave_cmd_pkg.sv ----
// constants for the serial slave read/write/diagnosis command handler
package slave_cmd_pkg;
    localparam logic [7:0]  FC_READ      = 8'h03;
    localparam logic [7:0]  FC_WRITE     = 8'h06;
    localparam logic [7:0]  FC_DIAG      = 8'h08;
    localparam logic [7:0]  FC_EXC_FLAG  = 8'h80;
    localparam logic [7:0]  EXC_FUNC     = 8'h01;
    localparam logic [7:0]  EXC_ADDR     = 8'h02;
    localparam logic [7:0]  EXC_DATA     = 8'h03;
    localparam logic [7:0]  BCAST_ADDR   = 8'h00;
    localparam logic [15:0] DIAG_SUB_ECHO = 16'h0000;
    localparam logic [15:0] REG_LIMIT    = 16'h2000;
    localparam logic [15:0] MAX_REGS     = 16'h0010;
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'hA001;
    localparam logic [3:0]  QUERY_LEN    = 4'h8;
    localparam logic [3:0]  EXC_LEN      = 4'h3;
    localparam logic [3:0]  READ_HDR_LEN = 4'h3;

    typedef enum logic [2:0] {
        ST_RX, ST_EXEC, ST_FETCH, ST_TX, ST_CRC_LO, ST_CRC_HI
    } slave_state_e;
endpackage

// ---- tb/slave_cmd_checker.sv ----
// assertion checker for the serial slave command handler
`timescale 1ns/10ps
module slave_cmd_checker #(
    parameter int ADDR_W = 13
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_b,
    // receive side
    input wire logic              rx_frame_end,
    // transmit side
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_ready,
    input wire logic              tx_frame_end,
    // register space
    input wire logic              reg_rd,
    input wire logic              reg_wr,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0]       reg_wdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RD_PULSE: assert property (reg_rd |=> !reg_rd)
        else $error("read strobe too long");
    AST_WR_PULSE: assert property (reg_wr |=> !reg_wr)
        else $error("write strobe too long");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte changed before accept");
    AST_END_WITH_BYTE: assert property (tx_frame_end |-> tx_valid)
        else $error("frame end without byte");
    AST_END_DROPS: assert property (tx_valid && tx_ready && tx_frame_end |=> !tx_valid)
        else $error("bytes after frame end");
    AST_WR_TIMING: assert property (reg_wr |-> $past(rx_frame_end, 2))
        else $error("write not two cycles after frame end");
    AST_WR_STANDS: assert property (reg_wr |=> $stable(reg_addr) && $stable(reg_wdata))
        else $error("write address or data moved");
    AST_QUIET_EXEC: assert property (rx_frame_end && !tx_valid |=> !tx_valid && !reg_wr)
        else $error("activity in the check cycle");
endmodule

bind slave_cmd slave_cmd_checker #(.ADDR_W(ADDR_W)) i_slave_cmd_checker (
    .clk(clk), .rst_b(rst_b), .rx_frame_end(rx_frame_end), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_frame_end(tx_frame_end), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

// ---- tb/serial_master_model.sv ----
// behavioural bus master: sends queries, collects response bytes
`timescale 1ns/10ps
module serial_master_model (
    // clock
    input  wire logic       clk,
    // query side
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_frame_end,
    // response side
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    input  wire logic       tx_frame_end
);
    logic [7:0] resp[$];
    int         end_at = -1;
    bit         slow = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_frame_end = 1'b0;
        tx_ready = 1'b1;
    end
    // gap of one idle cycle before the end mark, as the receiver needs
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge clk);
            #1 rx_valid = 1'b1;
            rx_data = q[i];
        end
        @(posedge clk);
        #1 rx_valid = 1'b0;
        rx_data = ~rx_data;
        @(posedge clk);
        #1 rx_frame_end = 1'b1;
        @(posedge clk);
        #1 rx_frame_end = 1'b0;
    endtask
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            if (tx_frame_end) end_at = resp.size();
            resp.push_back(tx_data);
        end
        tx_ready <= #1 slow ? 1'($urandom) : 1'b1;
    end
endmodule

// ---- tb/serial_slave_read_write_diag_test.sv ----
// self-checking bench for the serial slave command handler
`timescale 1ns/10ps
module serial_slave_read_write_diag_test;
    import slave_cmd_pkg::*;
    logic        clk = 0, rst_b = 0, tx_valid, tx_ready, tx_frame_end, reg_rd, reg_wr;
    logic        rx_valid, rx_frame_end;
    logic [7:0]  own_addr = 8'h02, rx_data, tx_data;
    logic [12:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata = 16'h0000;
    logic [15:0] mem[8192];
    int          exp_mem[8192];
    int          err_count = 0, total_checks = 0, cyc = 0;
    slave_cmd #(.ADDR_W(13)) i_slave_cmd (.clk(clk), .rst_b(rst_b), .own_addr(own_addr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_end(rx_frame_end),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .tx_frame_end(tx_frame_end), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    serial_master_model i_serial_master_model (.clk(clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_frame_end(rx_frame_end), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .tx_frame_end(tx_frame_end));
    always #5 clk = ~clk;
    // register space, one cycle read latency; stale data is scrambled
    always @(posedge clk) begin
        #1;
        if (reg_wr) mem[reg_addr] = reg_wdata;
        reg_rdata = reg_rd ? mem[reg_addr] : ~reg_rdata;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c = CRC_INIT;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction
    task automatic query(input logic [7:0] a, f, input logic [15:0] w1, w2, input int bad = 0);
        logic [7:0]  q[$], r[$];
        logic [15:0] v;
        int          n;
        q = {a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
        v = crc16(q);
        q.push_back(v[7:0] ^ 8'(bad == 1));
        q.push_back(v[15:8]);
        // a ninth byte must make the slave drop the frame
        if (bad == 2) q.push_back(8'h00);
        if (!bad && (a == own_addr || a == BCAST_ADDR)) begin
            if (f == FC_READ && (w2 == 16'h0000 || w2 > MAX_REGS))
                r = {a, f | FC_EXC_FLAG, EXC_DATA};
            else if (f == FC_READ && {1'b0, w1} + w2 > REG_LIMIT)
                r = {a, f | FC_EXC_FLAG, EXC_ADDR};
            else if (f == FC_READ) begin
                r = {a, f, 8'(2 * w2)};
                for (int i = 0; i < w2; i++) begin
                    v = 16'(exp_mem[w1 + i]);
                    r.push_back(v[15:8]);
                    r.push_back(v[7:0]);
                end
            end else if (f == FC_WRITE && w1 >= REG_LIMIT)
                r = {a, f | FC_EXC_FLAG, EXC_ADDR};
            else if (f == FC_WRITE || (f == FC_DIAG && w1 == DIAG_SUB_ECHO)) begin
                if (f == FC_WRITE) exp_mem[w1] = w2;
                r = q;
            end else
                r = {a, f | FC_EXC_FLAG, EXC_FUNC};
            // only echoes are eight bytes long, everything else needs a fresh check
            if (r.size() != 8) begin
                v = crc16(r);
                r.push_back(v[7:0]);
                r.push_back(v[15:8]);
            end
            if (a == BCAST_ADDR) r.delete();
        end
        i_serial_master_model.resp.delete();
        i_serial_master_model.end_at = -1;
        i_serial_master_model.send(q);
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (r.size() > 0 && i_serial_master_model.resp.size() >= r.size()) break;
            if (r.size() == 0 && n == 30) break;
        end
        repeat (2) @(posedge clk);
        chk(16'(i_serial_master_model.resp.size()), 16'(r.size()));
        chk(16'(i_serial_master_model.end_at), 16'(r.size() - 1));
        foreach (r[i]) chk(i_serial_master_model.resp[i], r[i]);
    endtask
    logic [7:0]  fcs[9] = '{FC_READ, FC_READ, FC_READ, FC_READ, FC_READ, FC_WRITE,
                            FC_WRITE, FC_DIAG, 8'h10};
    logic [15:0] w1s[9] = '{16'h1FF0, 16'h1FF1, 16'h0000, 16'h0000, 16'h0100, 16'h1FFF,
                            16'h2000, 16'h0001, 16'h0000};
    logic [15:0] w2s[9] = '{16'h0010, 16'h0010, 16'h0000, 16'h0011, 16'h0001, 16'hA5A5,
                            16'h0001, 16'h1234, 16'h0001};
    initial begin
        logic [7:0]  f;
        void'($urandom(32'h6836_5ba6));
        foreach (mem[i]) begin
            mem[i] = 16'($urandom);
            exp_mem[i] = mem[i];
        end
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge clk);
        query(8'h02, FC_WRITE, 16'h024B, 16'h0050);
        #1 own_addr = 8'h01;
        query(8'h01, FC_READ, 16'h0402, 16'h0004);
        #1 own_addr = 8'h03;
        query(8'h03, FC_DIAG, 16'h0000, 16'h1234);
        #1 own_addr = 8'h11;
        for (int i = 0; i < 9; i++)
            query(8'h11, fcs[i], w1s[i], w2s[i]);
        query(8'h00, FC_WRITE, 16'h0123, 16'hBEEF);
        query(8'h11, FC_READ, 16'h0123, 16'h0001);
        query(8'h11, FC_DIAG, 16'h0000, 16'h5555, 1);
        query(8'h11, FC_DIAG, 16'h0000, 16'h5555, 2);
        query(8'h12, FC_DIAG, 16'h0000, 16'h5555);
        i_serial_master_model.slow = 1;
        repeat (30) begin
            f = fcs[$urandom_range(8)];
            query(($urandom_range(3) != 0) ? 8'h11 : 8'h00, f, 16'($urandom_range(16'h2008)),
                  (f == FC_READ) ? 16'($urandom_range(17)) : 16'($urandom));
        end
        print_verdict();
    end
endmodule
